//--- rtl/cscr_pkg.sv
// Constants, codes and carriers for the clock source control block
package cscr_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_HF_START = 12'h000;
   localparam logic [11:0] OFF_HF_STOP = 12'h004;
   localparam logic [11:0] OFF_LF_START = 12'h008;
   localparam logic [11:0] OFF_LF_STOP = 12'h00c;
   localparam logic [11:0] OFF_CAL = 12'h010;
   localparam logic [11:0] OFF_CT_GO = 12'h014;
   localparam logic [11:0] OFF_CT_HALT = 12'h018;
   localparam logic [11:0] OFF_EV_HF = 12'h100;
   localparam logic [11:0] OFF_EV_LF = 12'h104;
   localparam logic [11:0] OFF_EV_DONE = 12'h10c;
   localparam logic [11:0] OFF_EV_CAL_TIMER_TIMEOUT_EVT = 12'h110;
   localparam logic [11:0] OFF_IEN_SET = 12'h304;
   localparam logic [11:0] OFF_IEN_CLR = 12'h308;
   localparam logic [11:0] OFF_HF_REQ = 12'h408;
   localparam logic [11:0] OFF_HF_STAT = 12'h40c;
   localparam logic [11:0] OFF_LF_REQ = 12'h414;
   localparam logic [11:0] OFF_LF_STAT = 12'h418;
   localparam logic [11:0] OFF_LF_SNAP = 12'h41c;
   localparam logic [11:0] OFF_LF_SEL = 12'h518;
   localparam logic [11:0] OFF_CAL_IVL = 12'h538;
   // Event and enable bit positions
   localparam int EVT_HF = 0;
   localparam int EVT_LF = 1;
   localparam int EVT_DONE = 3;
   localparam int EVT_CAL_TIMER_TIMEOUT_EVT = 4;
   localparam logic [4:0] EVT_MASK = 5'h1b;
   localparam int STATE_BIT = 16;
   localparam int BYPASS_BIT = 16;
   localparam int EXT_BIT = 17;
   localparam int IVL_W = 7;
   localparam logic [6:0] IVL_RST = 7'h00;
   localparam logic [31:0] LF_SEL_RST = 32'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Calibration timer step, 0.25 s
   localparam int CLK_HZ = 50000000;
   localparam int CAL_STEP_MS = 250;
   localparam int CAL_STEP_CYCLES = CLK_HZ / 1000 * CAL_STEP_MS;
   localparam int TICK_W = 24;
   typedef enum logic [1:0] {
      LFSRC_RC = 2'b00,
      LFSRC_XTAL = 2'b01,
      LFSRC_SYNTH = 2'b10
   } cscr_lfsrc_t;
   typedef enum logic {
      CT_IDLE = 1'b0,
      CT_RUN = 1'b1
   } cscr_ct_state_t;
   typedef struct packed {
      logic fast_xtal_en;
      logic slow_en;
      logic [1:0] slow_src;
      logic slow_bypass;
      logic slow_external;
      logic cal_start;
   } cscr_osc_ctrl_t;
   typedef struct packed {
      logic fast_clock_running;
      logic fast_xtal_running;
      logic slow_running;
      logic cal_done;
   } cscr_osc_stat_t;
endpackage

//--- rtl/cscr_top.sv
// Clock source control registers with AXI4-Lite slave and calibration timer
// Contract
// - Writing 1 to fast crystal start task requests the crystal; no state.
// - Writing 1 to fast crystal stop task stops the crystal.
// - Writing 1 to slow start task starts slow clock from selected source.
// - Writing 1 to slow stop task stops the slow clock source.
// - Writing 1 to calibrate task begins RC oscillator calibration.
// - Timer go task starts calibration timer; halt task stops it.
// - Started events set when fast crystal or slow clock starts running.
// - Calibration done event sets when calibration completes.
// - Timeout event sets when calibration timer expires.
// - Event registers read 1 once generated, 0 otherwise; software writable.
// - Enable set: write 1 enables event interrupt, 0 no effect; reads enables.
// - Fast run status reads 1 once fast start task triggered.
// - Fast status source reads 0 internal, 1 crystal.
// - Fast status state reads 1 while fast clock runs.
// - Slow run status reads 1 once slow start task triggered.
// - Slow start latches source selection into read-only snapshot.
// - Slow source codes: 0 RC, 1 crystal, 2 synthesized.
// - Source select holds code, bypass, external bits; resets to RC.
// - External bit only with crystal code; bypass means rail-to-rail.
// - Timer counts down interval in 0.25 s steps, times out, stops.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module cscr_top
   import cscr_pkg::*;
#(
   parameter int STEP_CYCLES = CAL_STEP_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cscr_osc_stat_t osc_stat,
   output cscr_osc_ctrl_t osc_ctrl,
   output logic irq
);

   if (STEP_CYCLES < 1 || STEP_CYCLES > 16777215) begin : g_chk
      $error("STEP_CYCLES must fit 1 to 2**24-1");
   end

   localparam logic [TICK_W-1:0] STEP_LAST = TICK_W'(STEP_CYCLES - 1);

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return hit(a, OFF_HF_START) | hit(a, OFF_HF_STOP)
         | hit(a, OFF_LF_START) | hit(a, OFF_LF_STOP)
         | hit(a, OFF_CAL) | hit(a, OFF_CT_GO)
         | hit(a, OFF_CT_HALT) | hit(a, OFF_EV_HF)
         | hit(a, OFF_EV_LF) | hit(a, OFF_EV_DONE)
         | hit(a, OFF_EV_CAL_TIMER_TIMEOUT_EVT) | hit(a, OFF_IEN_SET)
         | hit(a, OFF_IEN_CLR) | hit(a, OFF_HF_REQ)
         | hit(a, OFF_HF_STAT) | hit(a, OFF_LF_REQ)
         | hit(a, OFF_LF_STAT) | hit(a, OFF_LF_SNAP)
         | hit(a, OFF_LF_SEL) | hit(a, OFF_CAL_IVL);
   endfunction

   // Bus slave state
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic aw_have_q, w_have_q;
   logic [1:0] bresp_q, rresp_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;

   // Block state
   logic [4:0] evt_q, evt_d, ien_q, ien_d;
   logic [31:0] lf_sel_q, lf_sel_d;
   logic [IVL_W-1:0] ivl_q, ivl_d;
   logic [1:0] snap_q;
   cscr_osc_ctrl_t ctrl_q, ctrl_d;
   logic hf_prev_q, lf_prev_q, irq_q;
   cscr_ct_state_t ct_state_q, ct_state_d;
   logic [IVL_W-1:0] ct_left_q, ct_left_d;
   logic [TICK_W-1:0] ct_tick_q, ct_tick_d;

   wire aw_hs = s_axi_awvalid & awready_q;
   wire w_hs = s_axi_wvalid & wready_q;
   wire ar_hs = s_axi_arvalid & arready_q;
   wire wr_go = aw_have_q & w_have_q;
   wire [31:0] wmask = strb_mask(wstrb_q);
   wire [31:0] wd = wdata_q & wmask;
   wire [11:0] wa = awaddr_q;
   wire [11:0] ra = s_axi_araddr;
   wire b0 = wr_go & wd[0];

   // Task triggers, one cycle each
   wire t_hfs = b0 & hit(wa, OFF_HF_START);
   wire t_hfp = b0 & hit(wa, OFF_HF_STOP);
   wire t_lfs = b0 & hit(wa, OFF_LF_START);
   wire t_lfp = b0 & hit(wa, OFF_LF_STOP);
   wire t_cal = b0 & hit(wa, OFF_CAL);
   wire t_ctg = b0 & hit(wa, OFF_CT_GO);
   wire t_cth = b0 & hit(wa, OFF_CT_HALT);

   // Hardware event sources
   wire hf_rise = osc_stat.fast_xtal_running & ~hf_prev_q;
   wire lf_rise = osc_stat.slow_running & ~lf_prev_q;
   wire ct_run = ct_state_q == CT_RUN;
   wire step_end = ct_tick_q == STEP_LAST;
   // A go in the expiry cycle reloads instead of timing out, so the timer keeps running
   wire ct_to = ct_run & ~t_cth & ~t_ctg & step_end & (ct_left_q <= IVL_W'(1));

   // Events from run level rises, done pulse and expiry
   wire [4:0] ev_set = {ct_to, osc_stat.cal_done, 1'b0, lf_rise, hf_rise};
   wire ev_wen = wr_go & wstrb_q[0];
   wire [4:0] ev_wr = {5{ev_wen}} & {hit(wa, OFF_EV_CAL_TIMER_TIMEOUT_EVT),
      hit(wa, OFF_EV_DONE), 1'b0, hit(wa, OFF_EV_LF), hit(wa, OFF_EV_HF)};

   // Hardware set wins over a software write of 0
   assign evt_d = EVT_MASK & (ev_set | (ev_wr & {5{wd[0]}})
      | (~ev_wr & evt_q));

   wire ien_s = wr_go & hit(wa, OFF_IEN_SET);
   wire ien_c = wr_go & hit(wa, OFF_IEN_CLR);
   // Set and clear only touch bits written as 1
   assign ien_d = EVT_MASK & ((ien_q | ({5{ien_s}} & wd[4:0]))
      & ~({5{ien_c}} & wd[4:0]));

   wire sel_w = wr_go & hit(wa, OFF_LF_SEL);
   wire [31:0] sel_m = (lf_sel_q & ~wmask) | wd;
   wire [31:0] sel_keep = 32'h00030003;
   assign lf_sel_d = sel_w ? (sel_m & sel_keep) : lf_sel_q;

   wire ivl_w = wr_go & hit(wa, OFF_CAL_IVL) & wstrb_q[0];
   assign ivl_d = ivl_w ? wd[IVL_W-1:0] : ivl_q;

   // External source reaches the oscillator only with crystal code
   wire ext_ok = lf_sel_q[1:0] == LFSRC_XTAL;

   always_comb begin
      ctrl_d = ctrl_q;
      ctrl_d.cal_start = t_cal;
      // Crystal request follows start and stop tasks
      if (t_hfs) begin
         ctrl_d.fast_xtal_en = 1'b1;
      end else if (t_hfp) begin
         ctrl_d.fast_xtal_en = 1'b0;
      end
      if (t_lfs) begin
         ctrl_d.slow_en = 1'b1;
         ctrl_d.slow_src = lf_sel_q[1:0];
         ctrl_d.slow_bypass = lf_sel_q[BYPASS_BIT];
         ctrl_d.slow_external = lf_sel_q[EXT_BIT] & ext_ok;
      end else if (t_lfp) begin
         // Stop drops the slow clock request
         ctrl_d.slow_en = 1'b0;
      end
   end

   always_comb begin
      ct_state_d = ct_state_q;
      ct_left_d = ct_left_q;
      ct_tick_d = '0;
      case (ct_state_q)
         CT_IDLE: begin
            if (t_ctg) begin
               ct_state_d = CT_RUN;
               ct_left_d = ivl_q;
            end
         end
         CT_RUN: begin
            if (t_ctg) begin
               ct_left_d = ivl_q;
            end else if (t_cth || ct_to) begin
               ct_state_d = CT_IDLE;
               ct_left_d = '0;
            end else if (step_end) begin
               ct_left_d = ct_left_q - IVL_W'(1);
            end else begin
               ct_tick_d = ct_tick_q + TICK_W'(1);
            end
         end
         default: begin
            ct_state_d = CT_IDLE;
         end
      endcase
   end

   // Fast status from the oscillator levels
   wire [31:0] hf_stat = {15'h0, osc_stat.fast_clock_running,
      15'h0, osc_stat.fast_xtal_running};
   // Slow status carries the latched source code
   wire [31:0] lf_stat = {15'h0, osc_stat.slow_running,
      14'h0, ctrl_q.slow_src};
   wire [31:0] ien_rd = {27'h0, ien_q};

   // Run status reads the task request flops
   wire [31:0] rd_word =
      hit(ra, OFF_EV_HF) ? {31'h0, evt_q[EVT_HF]} :
      hit(ra, OFF_EV_LF) ? {31'h0, evt_q[EVT_LF]} :
      hit(ra, OFF_EV_DONE) ? {31'h0, evt_q[EVT_DONE]} :
      hit(ra, OFF_EV_CAL_TIMER_TIMEOUT_EVT) ? {31'h0, evt_q[EVT_CAL_TIMER_TIMEOUT_EVT]} :
      hit(ra, OFF_IEN_SET) ? ien_rd :
      hit(ra, OFF_IEN_CLR) ? ien_rd :
      hit(ra, OFF_HF_REQ) ? {31'h0, ctrl_q.fast_xtal_en} :
      hit(ra, OFF_HF_STAT) ? hf_stat :
      hit(ra, OFF_LF_REQ) ? {31'h0, ctrl_q.slow_en} :
      hit(ra, OFF_LF_STAT) ? lf_stat :
      hit(ra, OFF_LF_SNAP) ? {30'h0, snap_q} :
      hit(ra, OFF_LF_SEL) ? lf_sel_q :
      hit(ra, OFF_CAL_IVL) ? {25'h0, ivl_q} : 32'h0;

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_hs) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Read channel: data sampled on the address edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else begin
         if (ar_hs) begin
            rdata_q <= rd_word;
            rresp_q <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
         end
         if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // Registers of the block itself
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_q <= 5'h00;
         ien_q <= 5'h00;
         lf_sel_q <= LF_SEL_RST;
         ivl_q <= IVL_RST;
         snap_q <= LFSRC_RC;
         ctrl_q <= '0;
         hf_prev_q <= 1'b0;
         lf_prev_q <= 1'b0;
         irq_q <= 1'b0;
         ct_state_q <= CT_IDLE;
         ct_left_q <= '0;
         ct_tick_q <= '0;
      end else begin
         evt_q <= evt_d;
         ien_q <= ien_d;
         lf_sel_q <= lf_sel_d;
         ivl_q <= ivl_d;
         snap_q <= t_lfs ? lf_sel_q[1:0] : snap_q;
         ctrl_q <= ctrl_d;
         hf_prev_q <= osc_stat.fast_xtal_running;
         lf_prev_q <= osc_stat.slow_running;
         // Interrupt from enabled flags, one cycle behind them
         irq_q <= |(evt_q & ien_q);
         ct_state_q <= ct_state_d;
         ct_left_q <= ct_left_d;
         ct_tick_q <= ct_tick_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign osc_ctrl = ctrl_q;
   assign irq = irq_q;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_cal_pulse;
      osc_ctrl.cal_start ##1 !osc_ctrl.cal_start;
   endsequence

   a_hf_request_on: assert property (t_hfs |=> osc_ctrl.fast_xtal_en)
      else $error("crystal request not raised by start task");
   a_hf_request_off: assert property (t_hfp |=> !osc_ctrl.fast_xtal_en)
      else $error("crystal request not dropped by stop task");
   a_lf_start_snap: assert property (t_lfs |=> osc_ctrl.slow_en
      && snap_q == $past(lf_sel_q[1:0]))
      else $error("slow start did not latch source");
   a_lf_stop_drop: assert property (t_lfp && !t_lfs |=> !osc_ctrl.slow_en)
      else $error("slow stop did not drop request");
   a_cal_one_pulse: assert property (t_cal |=> s_cal_pulse)
      else $error("calibration start not one cycle");
   a_ct_go_run: assert property (t_ctg |=> ct_run && ct_left_q == $past(ivl_q))
      else $error("timer did not load interval");
   a_hf_evt_set: assert property (hf_rise |=> evt_q[EVT_HF])
      else $error("fast started event lost");
   a_done_evt_set: assert property (osc_stat.cal_done |=> evt_q[EVT_DONE])
      else $error("calibration done event lost");
   a_lf_evt_set: assert property (lf_rise |=> evt_q[EVT_LF])
      else $error("slow started event lost");
   a_ct_halt_stop: assert property (ct_run && t_cth |=> !ct_run)
      else $error("timer kept running after halt");
   a_ct_timeout: assert property (ct_to |=> evt_q[EVT_CAL_TIMER_TIMEOUT_EVT] && !ct_run)
      else $error("timer expiry did not raise event and stop");
   a_ien_write: assert property (ien_s |=> (ien_q & ($past(wd[4:0]) & EVT_MASK))
      == ($past(wd[4:0]) & EVT_MASK))
      else $error("enable set did not take");
   a_irq_follow: assert property (##1 irq == $past(|(evt_q & ien_q)))
      else $error("interrupt does not follow enabled flags");
endmodule

//--- testbench/cscr_osc_model.sv
// Behavioural model of the crystal, slow clock and calibration side of the block
`timescale 1ns/10ps
module cscr_osc_model
   import cscr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] lag,
   input wire cscr_osc_ctrl_t osc_ctrl,
   output cscr_osc_stat_t osc_stat
);
   logic [3:0] fx_q;
   logic [3:0] sl_q;
   logic [3:0] cal_q;
   logic cal_busy_q;
   logic fx_up;
   logic sl_up;
   logic cal_hit;
   // Lag must stay above zero and only change while both sources are off
   assign fx_up = osc_ctrl.fast_xtal_en && fx_q == lag;
   assign sl_up = osc_ctrl.slow_en && sl_q == lag;
   assign cal_hit = cal_busy_q && cal_q == lag;
   assign osc_stat = {fx_up, fx_up, sl_up, cal_hit};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fx_q <= 4'h0;
         sl_q <= 4'h0;
         cal_q <= 4'h0;
         cal_busy_q <= 1'b0;
      end else begin
         // Start-up counts restart whenever the request drops
         fx_q <= !osc_ctrl.fast_xtal_en ? 4'h0 : (fx_up ? fx_q : fx_q + 4'h1);
         sl_q <= !osc_ctrl.slow_en ? 4'h0 : (sl_up ? sl_q : sl_q + 4'h1);
         if (osc_ctrl.cal_start) begin
            cal_busy_q <= 1'b1;
            cal_q <= 4'h0;
         end else if (cal_busy_q) begin
            cal_q <= cal_q + 4'h1;
            cal_busy_q <= !cal_hit;
         end
      end
   end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the clock source control registers
`timescale 1ns/10ps
module testbench
   import cscr_pkg::*;
;
   localparam logic [11:0] RST_LIST [12] = '{OFF_EV_HF, OFF_EV_LF, OFF_EV_DONE, OFF_EV_CAL_TIMER_TIMEOUT_EVT,
      OFF_IEN_SET, OFF_IEN_CLR, OFF_HF_REQ, OFF_HF_STAT, OFF_LF_REQ, OFF_LF_STAT, OFF_LF_SNAP,
      OFF_LF_SEL};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h0;
   logic [11:0] araddr = 12'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [3:0] lag = 4'h1;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   cscr_osc_ctrl_t osc_ctrl;
   cscr_osc_stat_t osc_stat;
   logic [1:0] bq [$];
   logic [33:0] rq [$];
   int n_fail = 0;
   int checks_done = 0;
   int cal_pulses = 0;
   logic [31:0] sel, r;
   logic [4:0] en;

   always #10 aclk = ~aclk;

   cscr_top #(.STEP_CYCLES(4)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_stat(osc_stat), .osc_ctrl(osc_ctrl), .irq(irq));

   cscr_osc_model osc (.aclk(aclk), .aresetn(aresetn), .lag(lag), .osc_ctrl(osc_ctrl),
      .osc_stat(osc_stat));

   task automatic chk(input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Called just after a rising edge; returns one edge after the response
   task automatic axw(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] er = RESP_OKAY);
      bit dn;
      dn = 0;
      bq.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!dn) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            dn = 1;
            bready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   task automatic axr(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] er = RESP_OKAY);
      bit dn;
      dn = 0;
      rq.push_back({er, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!dn) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            dn = 1;
            rready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   // Scoreboard: each response is matched with the oldest note
   always @(posedge aclk) begin
      // A response with no note left is counted as a mismatch
      if (bvalid && bready) chk(bq.size() > 0 ? 34'(bq.pop_front()) : 34'h3ffffffff, 34'(bresp));
      if (rvalid && rready) chk(rq.size() > 0 ? rq.pop_front() : 34'h3ffffffff, {rresp, rdata});
      if (osc_ctrl.cal_start) cal_pulses++;
   end

   initial begin
      wt(5000);
      chk(34'h0, 34'h1);
      end_sim;
   end

   initial begin
      wt(3);
      aresetn <= 1'b1;
      wt(1);
      void'($urandom(32'hc710));
      foreach (RST_LIST[i]) axr(RST_LIST[i], 32'h0);
      axr(12'h200, 32'h0, RESP_SLVERR);
      axw(12'h200, 32'h1, RESP_SLVERR);
      axw(OFF_HF_REQ, 32'h1);
      axr(OFF_HF_REQ, 32'h0);
      $display("test reset_and_map done");
      for (int k = 0; k < 2; k++) begin
         lag <= k ? 4'h7 : 4'h1;
         axw(OFF_HF_START, 32'h1);
         chk(34'h1, 34'(osc_ctrl.fast_xtal_en));
         axr(OFF_HF_REQ, 32'h1);
         wt(12);
         axr(OFF_HF_STAT, 32'h10001);
         axr(OFF_EV_HF, 32'h1);
         axw(OFF_HF_STOP, 32'h1);
         chk(34'h0, 34'(osc_ctrl.fast_xtal_en));
         axr(OFF_HF_STAT, 32'h0);
         axw(OFF_EV_HF, 32'h0);
      end
      $display("test fast_clock done");
      for (int c = 0; c < 3; c++) begin
         sel = (c == 1) ? 32'h30001 : 32'(c);
         axw(OFF_LF_SEL, sel);
         axr(OFF_LF_SEL, sel);
         axw(OFF_LF_START, 32'h1);
         chk(34'({1'b1, 2'(c), c == 1, c == 1}), 34'({osc_ctrl.slow_en, osc_ctrl.slow_src,
            osc_ctrl.slow_bypass, osc_ctrl.slow_external}));
         axr(OFF_LF_SNAP, 32'(c));
         axr(OFF_LF_REQ, 32'h1);
         wt(12);
         axr(OFF_LF_STAT, 32'h10000 | 32'(c));
         axr(OFF_EV_LF, 32'h1);
         axw(OFF_LF_STOP, 32'h1);
         chk(34'h0, 34'(osc_ctrl.slow_en));
         axw(OFF_EV_LF, 32'h0);
      end
      // Only the byte holding bypass and external is written; the code byte stays
      wstrb <= 4'h4;
      axw(OFF_LF_SEL, 32'hffffffff);
      axr(OFF_LF_SEL, 32'h00030002);
      wstrb <= 4'hf;
      axw(OFF_LF_SEL, 32'h0);
      axr(OFF_LF_SEL, 32'h0);
      $display("test slow_clock done");
      axw(OFF_CAL, 32'h1);
      wt(12);
      chk(34'h1, 34'(cal_pulses));
      axr(OFF_EV_DONE, 32'h1);
      axw(OFF_CAL_IVL, 32'h3);
      axr(OFF_CAL_IVL, 32'h3);
      axw(OFF_CT_GO, 32'h1);
      axw(OFF_CT_HALT, 32'h1);
      wt(20);
      axr(OFF_EV_CAL_TIMER_TIMEOUT_EVT, 32'h0);
      axw(OFF_CT_GO, 32'h1);
      wt(6);
      axr(OFF_EV_CAL_TIMER_TIMEOUT_EVT, 32'h0);
      wt(4);
      axr(OFF_EV_CAL_TIMER_TIMEOUT_EVT, 32'h1);
      $display("test calibration done");
      axw(OFF_EV_HF, 32'h1);
      axr(OFF_EV_HF, 32'h1);
      chk(34'h0, 34'(irq));
      axw(OFF_IEN_SET, 32'h1);
      chk(34'h1, 34'(irq));
      axw(OFF_IEN_CLR, 32'h1);
      chk(34'h0, 34'(irq));
      axw(OFF_IEN_SET, 32'h1);
      axw(OFF_EV_HF, 32'h0);
      chk(34'h0, 34'(irq));
      $display("test interrupt done");
      en = 5'h01;
      repeat (4) begin
         r = $urandom;
         axw(OFF_IEN_SET, r);
         en = en | (r[4:0] & EVT_MASK);
         axr(OFF_IEN_SET, 32'(en));
         chk(34'(|(en & 5'h18)), 34'(irq));
         r = $urandom;
         axw(OFF_IEN_CLR, r);
         en = en & ~r[4:0];
         axr(OFF_IEN_CLR, 32'(en));
      end
      $display("test enable_masks done");
      end_sim;
   end
endmodule
